// ### rtl/rcls_map.vh
// Register map, field positions and reset values of the receive lock and status block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef RCLS_MAP_VH
`define RCLS_MAP_VH

// Byte offsets of the registers
`define RCLS_OFF_CTRL 8'h00
`define RCLS_OFF_THRESH 8'h04
`define RCLS_OFF_STATUS 8'h08
`define RCLS_OFF_IRQ_STAT 8'h0C
`define RCLS_OFF_IRQ_MASK 8'h10

// Control register fields
`define RCLS_CTRL_LOCK_REF 0
`define RCLS_CTRL_LOCK_DATA 1
`define RCLS_CTRL_PROTO_LO 2
`define RCLS_CTRL_PROTO_HI 3
`define RCLS_CTRL_ALT_RD 4
`define RCLS_CTRL_MAN_ALIGN 5
`define RCLS_CTRL_IDLE_INFER 6
`define RCLS_CTRL_BONDED 7
`define RCLS_CTRL_W 8
`define RCLS_CTRL_RESET 8'h00

// Protocol configurations held in the control register
`define RCLS_PROTO_BASIC 2'h0
`define RCLS_PROTO_BASIC_8B10B 2'h1
`define RCLS_PROTO_PIPE 2'h2
`define RCLS_PROTO_GIGABIT_ETHERNET_CONFIG 2'h3

// Signal-detect threshold reset value
`define RCLS_THRESH_RESET 8'h40

// Status register fields
`define RCLS_ST_DATA_LOCK 0
`define RCLS_ST_SIGDET 1
`define RCLS_ST_FIFO_ERR 2
`define RCLS_ST_SLIP_LO 3
`define RCLS_ST_SLIP_HI 6
`define RCLS_ST_ELEC_IDLE 7

// Interrupt status and mask fields
`define RCLS_IRQ_LOCK 0
`define RCLS_IRQ_SIGDET 1
`define RCLS_IRQ_FIFO 2
`define RCLS_IRQ_W 3

// Slip count limit of the word aligner
`define RCLS_SLIP_LAST 4'h9

// Lock detector counts: serial transitions to reach data lock, clock cycles of silence to drop it
`define RCLS_LOCK_EDGES 8'h10
`define RCLS_IDLE_CYCLES 8'h40

// AHB transfer type
`define RCLS_HTRANS_NONSEQ 2'h2

`endif

// ### rtl/rcls_sync.v
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/10ps
module rcls_sync #(
    parameter WIDTH = 1
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_q; // First stage, read only by the second

    // Two stages; reset clears both
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            meta_q <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // rcls_sync

// ### rtl/rcls_slip_counter.v
// Word aligner slip counter, counts slipped bit positions 0 through 9.
// Assumes i_slip is a one-cycle pulse already in the clock domain.
`timescale 1ns/10ps
`include "rcls_map.vh"
module rcls_slip_counter (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_manual,
    input wire i_slip,
    output reg [3:0] o_count
);
    // Counts only in manual alignment; wraps after nine back to zero
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
            o_count <= 4'h0;
        else if (!i_manual)
            o_count <= 4'h0; // Automatic alignment reports no slip
        else if (i_slip)
        begin
            if (o_count == `RCLS_SLIP_LAST)
                o_count <= 4'h0;
            else
                o_count <= o_count + 4'h1;
        end
    end
endmodule // rcls_slip_counter

// ### rtl/rcls_top.v
// Receive channel lock-mode control and status, with an AHB-Lite register slave.
// Assumes one 40 MHz clock; serial line and analog level arrive asynchronously.
// What this block does
// - Optional fabric read strobe replaces default FIFO read
// - FIFO error flag high when full or empty
// - FIFO flag timed by transmit or core clock
// - Manual alignment reports slip count zero to nine
// - Serial bit stream enters on dedicated input
// - Lock output high for data, low reference
// - Lock-to-data control overrides lock-to-reference control
// - Controls 00 auto, 01 reference, 1x data
// - Signal detect high above programmed threshold
// - Signal detect only in 8B/10B basic, PIPE
// - Recovered clock output only in gigabit Ethernet
// - PIPE without inference shows inverted signal detect
`timescale 1ns/10ps
`include "rcls_map.vh"
module rcls_top #(
    parameter FIFO_DEPTH = 8,
    parameter RECOV_DIV = 4
) (
    input wire i_clock,
    input wire i_rst_b,
    // AHB-Lite slave
    input wire i_hsel,
    input wire [7:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    // Line side
    input wire i_serial_in,
    input wire [7:0] i_rx_level,
    input wire i_idle_inferred,
    input wire i_slip_req,
    // Phase-compensation FIFO strobes
    input wire i_pcf_wr,
    input wire i_pcf_rd_default,
    input wire i_pcf_rd_fabric,
    // Status outputs
    output reg o_data_locked,
    output reg o_signal_detect,
    output reg o_fifo_error,
    output reg [3:0] o_aligner_slip_count,
    output reg o_elec_idle,
    output reg o_recov_clk,
    output reg o_irq
);
    localparam ST_REF = 1'b0; // Locked to reference clock
    localparam ST_DATA = 1'b1; // Locked to incoming data

    reg [`RCLS_CTRL_W-1:0] ctrl_q; // Control register
    reg [7:0] thresh_q; // Signal-detect threshold
    reg [`RCLS_IRQ_W-1:0] irq_stat_q; // Sticky event bits
    reg [`RCLS_IRQ_W-1:0] irq_mask_q; // Interrupt enables
    reg [7:0] addr_q; // Latched write address
    reg wr_pend_q; // Write data phase pending
    reg lock_state_q; // Recovery lock state
    reg [7:0] edge_cnt_q; // Transitions seen while in reference lock
    reg [7:0] quiet_cnt_q; // Cycles without a transition
    reg serial_prev_q; // Last synchronised serial bit
    reg [7:0] fifo_cnt_q; // Phase-compensation FIFO occupancy
    reg [7:0] div_cnt_q; // Recovered clock divider
    reg slip_prev_q; // Slip request edge detector
    reg sigdet_prev_q; // Previous signal-detect
    reg lock_prev_q; // Previous lock state
    reg ferr_prev_q; // Previous FIFO error

    wire serial_s; // Synchronised serial bit
    wire idle_inf_s; // Synchronised idle inference
    wire slip_s; // Synchronised slip request
    wire [7:0] level_s; // Synchronised analog level code
    wire [3:0] slip_count; // Counter output
    wire [1:0] lock_ctrl; // {lock-to-data, lock-to-reference}
    wire [1:0] proto; // Protocol configuration
    wire addr_phase; // Valid address phase taken
    wire rd_take; // Read taken this cycle
    wire rd_stat_clr; // Read of interrupt status
    wire serial_edge; // Transition on serial line
    wire sigdet_allowed; // Signal detect exists in this configuration
    wire sigdet_now; // Level compare result
    wire fifo_rd; // Selected FIFO read strobe
    wire fifo_full; // FIFO holds FIFO_DEPTH words
    wire fifo_empty; // FIFO holds nothing
    wire [`RCLS_IRQ_W-1:0] irq_events; // Event pulses this cycle
    wire [31:0] rd_mux; // Read data selected
    reg [`RCLS_CTRL_W-1:0] ctrl_d;

    // Line inputs are asynchronous and pass two stages first
    rcls_sync #(
        .WIDTH(11)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_async({i_serial_in, i_idle_inferred, i_slip_req, i_rx_level}),
        .o_sync({serial_s, idle_inf_s, slip_s, level_s})
    );

    // Slip counter advances on each rising slip request in manual alignment
    rcls_slip_counter u_slip (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_manual(ctrl_q[`RCLS_CTRL_MAN_ALIGN]),
        .i_slip(slip_s & ~slip_prev_q),
        .o_count(slip_count)
    );

    // Word-aligned byte offset decode
    function [31:0] rd_word;
        input [7:0] addr;
        input [`RCLS_CTRL_W-1:0] ctrl;
        input [7:0] thr;
        input [7:0] status;
        input [`RCLS_IRQ_W-1:0] istat;
        input [`RCLS_IRQ_W-1:0] imask;
        begin
            case (addr)
                `RCLS_OFF_CTRL: rd_word = {24'h000000, ctrl};
                `RCLS_OFF_THRESH: rd_word = {24'h000000, thr};
                `RCLS_OFF_STATUS: rd_word = {24'h000000, status};
                `RCLS_OFF_IRQ_STAT: rd_word = {29'h00000000, istat};
                `RCLS_OFF_IRQ_MASK: rd_word = {29'h00000000, imask};
                default: rd_word = 32'h00000000; // Unmapped reads zero
            endcase
        end
    endfunction

    assign lock_ctrl = {ctrl_q[`RCLS_CTRL_LOCK_DATA], ctrl_q[`RCLS_CTRL_LOCK_REF]};
    assign proto = ctrl_q[`RCLS_CTRL_PROTO_HI:`RCLS_CTRL_PROTO_LO];
    assign addr_phase = i_hsel & i_hready & (i_htrans == `RCLS_HTRANS_NONSEQ);
    assign rd_take = addr_phase & ~i_hwrite;
    assign rd_stat_clr = rd_take & (i_haddr == `RCLS_OFF_IRQ_STAT);
    assign serial_edge = serial_s ^ serial_prev_q;
    assign sigdet_allowed = (proto == `RCLS_PROTO_BASIC_8B10B) | (proto == `RCLS_PROTO_PIPE);
    assign sigdet_now = sigdet_allowed & (level_s > thresh_q);
    // Alternate read strobe stands for the optional fabric read clock
    assign fifo_rd = ctrl_q[`RCLS_CTRL_ALT_RD] ? i_pcf_rd_fabric : i_pcf_rd_default;
    assign fifo_full = (fifo_cnt_q == FIFO_DEPTH[7:0]);
    assign fifo_empty = (fifo_cnt_q == 8'h00);
    assign irq_events = {(fifo_full | fifo_empty) & ~ferr_prev_q,
                         o_signal_detect ^ sigdet_prev_q,
                         o_data_locked ^ lock_prev_q};
    assign rd_mux = rd_word(i_haddr, ctrl_q, thresh_q,
                            {o_elec_idle, o_aligner_slip_count, o_fifo_error, o_signal_detect, o_data_locked},
                            irq_stat_q, irq_mask_q);

    // Write size is ignored; any write loads the whole register from the low data bits; words are expected
    always @*
    begin
        ctrl_d = ctrl_q;
        if (wr_pend_q && addr_q == `RCLS_OFF_CTRL)
            ctrl_d = i_hwdata[`RCLS_CTRL_W-1:0];
    end

    // AHB slave: zero wait states, always OKAY; read data registered at the address phase
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            addr_q <= 8'h00;
            wr_pend_q <= 1'b0;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend_q <= addr_phase & i_hwrite;
            if (addr_phase)
                addr_q <= i_haddr;
            if (rd_take)
                o_hrdata <= rd_mux;
        end
    end

    // Software-written registers, applied in the write data phase
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= `RCLS_CTRL_RESET;
            thresh_q <= `RCLS_THRESH_RESET;
            irq_mask_q <= {`RCLS_IRQ_W{1'b0}};
        end
        else
        begin
            ctrl_q <= ctrl_d;
            if (wr_pend_q && addr_q == `RCLS_OFF_THRESH)
                thresh_q <= i_hwdata[7:0];
            if (wr_pend_q && addr_q == `RCLS_OFF_IRQ_MASK)
                irq_mask_q <= i_hwdata[`RCLS_IRQ_W-1:0];
        end
    end

    // Sticky events; a read clears them, but a new event in that cycle survives
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
            irq_stat_q <= {`RCLS_IRQ_W{1'b0}};
        else if (rd_stat_clr)
            irq_stat_q <= irq_events;
        else
            irq_stat_q <= irq_stat_q | irq_events;
    end

    // Recovery lock state: manual modes follow the controls, auto watches the line
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            lock_state_q <= ST_REF;
            edge_cnt_q <= 8'h00;
            quiet_cnt_q <= 8'h00;
            serial_prev_q <= 1'b0;
        end
        else
        begin
            serial_prev_q <= serial_s;
            // Quiet counter saturates; a transition restarts it
            if (serial_edge)
                quiet_cnt_q <= 8'h00;
            else if (quiet_cnt_q != `RCLS_IDLE_CYCLES)
                quiet_cnt_q <= quiet_cnt_q + 8'h01;
            if (lock_ctrl[1])
            begin
                lock_state_q <= ST_DATA;
                edge_cnt_q <= 8'h00;
            end
            else if (lock_ctrl[0])
            begin
                lock_state_q <= ST_REF;
                edge_cnt_q <= 8'h00;
            end
            else
            begin
                case (lock_state_q)
                    ST_REF:
                    begin
                        // Enough line activity means data is usable
                        if (edge_cnt_q == `RCLS_LOCK_EDGES)
                        begin
                            lock_state_q <= ST_DATA;
                            edge_cnt_q <= 8'h00;
                        end
                        else if (serial_edge)
                            edge_cnt_q <= edge_cnt_q + 8'h01;
                    end
                    ST_DATA:
                    begin
                        // A silent line cannot be tracked; fall back to reference
                        if (quiet_cnt_q == `RCLS_IDLE_CYCLES)
                            lock_state_q <= ST_REF;
                    end
                    default: lock_state_q <= ST_REF;
                endcase
            end
        end
    end

    // Phase-compensation FIFO occupancy; overflow and underflow are blocked
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
            fifo_cnt_q <= 8'h00;
        else if ((i_pcf_wr && !fifo_full) && !(fifo_rd && !fifo_empty))
            fifo_cnt_q <= fifo_cnt_q + 8'h01;
        else if (!(i_pcf_wr && !fifo_full) && (fifo_rd && !fifo_empty))
            fifo_cnt_q <= fifo_cnt_q - 8'h01;
    end

    // Recovered clock divider, running only in gigabit Ethernet configuration
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            div_cnt_q <= 8'h00;
            o_recov_clk <= 1'b0;
        end
        else if (proto != `RCLS_PROTO_GIGABIT_ETHERNET_CONFIG)
        begin
            div_cnt_q <= 8'h00;
            o_recov_clk <= 1'b0;
        end
        else if (div_cnt_q == RECOV_DIV[7:0] - 8'h01)
        begin
            div_cnt_q <= 8'h00;
            o_recov_clk <= ~o_recov_clk;
        end
        else
            div_cnt_q <= div_cnt_q + 8'h01;
    end

    // Status outputs, all registered
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            o_data_locked <= 1'b0;
            o_signal_detect <= 1'b0;
            o_fifo_error <= 1'b1;
            o_aligner_slip_count <= 4'h0;
            o_elec_idle <= 1'b0;
            o_irq <= 1'b0;
            slip_prev_q <= 1'b0;
            sigdet_prev_q <= 1'b0;
            lock_prev_q <= 1'b0;
            ferr_prev_q <= 1'b1;
        end
        else
        begin
            o_data_locked <= (lock_state_q == ST_DATA);
            o_signal_detect <= sigdet_now;
            // Single clock stands for both the transmit and core clocks
            o_fifo_error <= fifo_full | fifo_empty;
            o_aligner_slip_count <= slip_count;
            if (proto != `RCLS_PROTO_PIPE)
                o_elec_idle <= 1'b0;
            else if (ctrl_q[`RCLS_CTRL_IDLE_INFER])
                o_elec_idle <= idle_inf_s;
            else
                o_elec_idle <= ~sigdet_now;
            o_irq <= |(irq_stat_q & irq_mask_q);
            slip_prev_q <= slip_s;
            sigdet_prev_q <= o_signal_detect;
            lock_prev_q <= o_data_locked;
            ferr_prev_q <= fifo_full | fifo_empty;
        end
    end
endmodule // rcls_top

// ### verif/rcls_top_assertions.sv
// Checker for the receive lock and status block, bound to rcls_top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module rcls_assertions #(
    parameter FIFO_DEPTH = 8
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_hsel,
    input wire [7:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] i_hwdata,
    input wire i_pcf_wr,
    input wire i_pcf_rd_default,
    input wire i_pcf_rd_fabric,
    input wire o_data_locked,
    input wire o_signal_detect,
    input wire o_fifo_error,
    input wire [3:0] o_aligner_slip_count,
    input wire o_elec_idle,
    input wire o_recov_clk
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    reg wr_ctrl_q; // Control write now in its data phase
    reg [7:0] ctrl_q; // Shadow of the control register
    reg [3:0] occ_q; // Shadow of the FIFO occupancy
    wire rd_now = ctrl_q[4] ? i_pcf_rd_fabric : i_pcf_rd_default;
    wire [1:0] proto = ctrl_q[3:2];
    wire wr_ok = i_pcf_wr && occ_q != FIFO_DEPTH; // Write that finds room
    wire rd_ok = rd_now && occ_q != 4'h0; // Read that finds a word
    // Shadows move on the same edges as the block, so no latency is guessed
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            wr_ctrl_q <= 1'b0;
            ctrl_q <= 8'h00;
            occ_q <= 4'h0;
        end
        else
        begin
            wr_ctrl_q <= i_hsel && i_hready && i_htrans == 2'h2 && i_hwrite && i_haddr == 8'h00;
            if (wr_ctrl_q)
                ctrl_q <= i_hwdata[7:0];
            // Strobes past full or empty are dropped; a dropped one does not cancel the other
            if (wr_ok && !rd_ok)
                occ_q <= occ_q + 4'h1;
            else if (rd_ok && !wr_ok)
                occ_q <= occ_q - 4'h1;
        end
    end
    slip_range_a: assert property (o_aligner_slip_count <= 4'h9) else $error("slip count above nine");
    slip_off_a: assert property (!ctrl_q[5] [*3] |-> o_aligner_slip_count == 4'h0) else $error("slip not cleared");
    fifo_flag_a: assert property (o_fifo_error == $past(occ_q == 4'h0 || occ_q == FIFO_DEPTH))
        else $error("fifo flag wrong");
    data_force_a: assert property (ctrl_q[1] [*3] |-> o_data_locked) else $error("data lock not forced");
    ref_force_a: assert property ((ctrl_q[1:0] == 2'h1) [*3] |-> !o_data_locked) else $error("ref lock lost");
    sigdet_gate_a: assert property ((proto != 2'h1 && proto != 2'h2) [*3] |-> !o_signal_detect)
        else $error("detect outside its modes");
    recov_gate_a: assert property ((proto != 2'h3) [*3] |-> !o_recov_clk) else $error("clock outside its mode");
    // High phase of four cycles matches the default divider
    // Only judged while the mode stays put, since leaving it drops the clock at once
    recov_period_a: assert property (proto == 2'h3 && $rose(o_recov_clk) ##1 (proto == 2'h3) [*4]
        |-> $past(o_recov_clk, 1) && $past(o_recov_clk, 2) && $past(o_recov_clk, 3) && !o_recov_clk)
        else $error("recovered clock period wrong");
    idle_inv_a: assert property ((proto == 2'h2 && !ctrl_q[6] && $stable(o_signal_detect)) [*4]
        |-> o_elec_idle == !o_signal_detect) else $error("idle not inverse of detect");
    cover property (ctrl_q[1:0] == 2'h0 && $rose(o_data_locked));
    cover property (o_aligner_slip_count == 4'h9);
    cover property (occ_q == FIFO_DEPTH);
endmodule // rcls_assertions
bind rcls_top rcls_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .i_hwdata(i_hwdata), .i_pcf_wr(i_pcf_wr), .i_pcf_rd_default(i_pcf_rd_default),
    .i_pcf_rd_fabric(i_pcf_rd_fabric), .o_data_locked(o_data_locked), .o_signal_detect(o_signal_detect),
    .o_fifo_error(o_fifo_error), .o_aligner_slip_count(o_aligner_slip_count), .o_elec_idle(o_elec_idle),
    .o_recov_clk(o_recov_clk));

// ### verif/rcls_fabric_model.sv
// Fabric-side user logic: brings the asynchronous status into its own clock.
// Assumes it shares the block's clock; two flops per bit before any use.
`timescale 1ns/10ps
module rcls_fabric_model (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_data_locked,
    input wire i_signal_detect,
    input wire [3:0] i_slip_count,
    output reg [5:0] o_status_sync
);
    reg [5:0] meta_q; // First stage, may go metastable
    // Two stages ahead of any use; a multi-bit count may skew by one edge
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            meta_q <= 6'h00;
            o_status_sync <= 6'h00;
        end
        else
        begin
            meta_q <= {i_slip_count, i_signal_detect, i_data_locked};
            o_status_sync <= meta_q;
        end
    end
endmodule // rcls_fabric_model

// ### verif/rx_cdr_lock_and_status_tb.sv
// Self-checking bench for the receive lock and status block.
// Assumes the register map header; never relies on zero wait states.
`timescale 1ns/10ps
`include "rcls_map.vh"
module rx_cdr_lock_and_status_tb;
    reg i_clock = 1'b0;
    reg i_rst_b = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg ser = 1'b0;
    reg [7:0] lvl = 8'h00;
    reg idl = 1'b0;
    reg slip = 1'b0;
    reg wr = 1'b0;
    reg rdd = 1'b0;
    reg rdf = 1'b0;
    reg p;
    reg [31:0] r;
    wire [31:0] hrdata;
    wire hrdy, hresp, lock, sd, ferr, eidle, rclk, irq;
    wire [3:0] cnt;
    wire [5:0] fab;
    integer mismatches = 0;
    integer check_count = 0;
    integer i, k, n;
    initial
    begin
        forever #12.5 i_clock = ~i_clock;
    end
    rcls_top u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_serial_in(ser), .i_rx_level(lvl), .i_idle_inferred(idl),
        .i_slip_req(slip), .i_pcf_wr(wr), .i_pcf_rd_default(rdd), .i_pcf_rd_fabric(rdf),
        .o_data_locked(lock), .o_signal_detect(sd), .o_fifo_error(ferr), .o_aligner_slip_count(cnt),
        .o_elec_idle(eidle), .o_recov_clk(rclk), .o_irq(irq));
    rcls_fabric_model u_fab (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_data_locked(lock),
        .i_signal_detect(sd), .i_slip_count(cnt), .o_status_sync(fab));
    task report_and_stop;
    begin
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task chk(input [8*10-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("unexpected %0s: expected %h, seen %h", nm, exp, seen);
        end
    end
    endtask
    task cyc(input integer c);
    begin
        repeat (c) @(posedge i_clock);
    end
    endtask
    // Bounded wait for hready; a stuck bus ends the run
    task bw;
        integer t;
    begin
        t = 0;
        @(posedge i_clock);
        while (hrdy !== 1'b1 && t < 50)
        begin
            @(posedge i_clock);
            t = t + 1;
        end
        if (t >= 50)
        begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    endtask
    // One single-word transfer: address phase, then data phase
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= `RCLS_HTRANS_NONSEQ;
        bw;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bw;
        r = hrdata;
        chk("hresp", hresp, 0);
    end
    endtask
    initial
    begin
        cyc(6);
        i_rst_b <= 1'b1;
        cyc(1);
        chk("fifo_err", ferr, 1);
        bus(0, `RCLS_OFF_THRESH, 0);
        chk("thresh", r, 32'h40);
        bus(1, 8'h14, 32'hFF);
        bus(0, 8'h14, 0);
        chk("unmapped", r, 0);
        $display("Test reset done");
        // Every lock-mode code, then automatic lock both ways
        bus(1, `RCLS_OFF_IRQ_MASK, 32'h1);
        for (k = 0; k < 4; k = k + 1)
        begin
            bus(1, `RCLS_OFF_CTRL, k);
            cyc(4);
            chk("lock", lock, k[1]);
            bus(0, `RCLS_OFF_STATUS, 0);
            chk("st_lock", r[0], k[1]);
        end
        chk("irq", irq, 1);
        bus(1, `RCLS_OFF_CTRL, 0);
        cyc(72);
        chk("auto_ref", lock, 0);
        for (i = 0; i < 20; i = i + 1)
        begin
            ser <= ~ser;
            cyc(3);
        end
        cyc(6);
        chk("auto_data", lock, 1);
        bus(0, `RCLS_OFF_IRQ_STAT, 0);
        chk("irq_stat", r[0], 1);
        cyc(2);
        chk("irq_clr", irq, 0);
        $display("Test lock done");
        // Detect at threshold boundary, idle and recovered clock per protocol
        for (k = 0; k < 8; k = k + 1)
        begin
            lvl <= k[0] ? 8'h41 : 8'h40;
            bus(1, `RCLS_OFF_CTRL, {k[2:1], 2'b00});
            cyc(5);
            chk("sigdet", sd, k[0] && (k[2:1] == 1 || k[2:1] == 2));
            chk("elec_idle", eidle, k[2:1] == 2 && !k[0]);
            // Exactly 32 edges, so the count does not depend on the divider's phase
            n = 0;
            p = rclk;
            repeat (32)
            begin
                @(posedge i_clock);
                if (rclk !== p)
                    n = n + 1;
                p = rclk;
            end
            chk("recov", n, k[2:1] == 3 ? 8 : 0);
        end
        idl <= 1'b1;
        bus(1, `RCLS_OFF_CTRL, 32'h48);
        cyc(5);
        chk("inferred", eidle, 1);
        $display("Test detect done");
        // Manual slips across the wrap, seen raw and through the fabric
        bus(1, `RCLS_OFF_CTRL, 32'h20);
        for (k = 1; k <= 12; k = k + 1)
        begin
            slip <= 1'b1;
            cyc(2);
            slip <= 1'b0;
            cyc(6);
            chk("slip", cnt, k % 10);
            chk("slip_fab", fab[5:2], k % 10);
        end
        bus(1, `RCLS_OFF_CTRL, 0);
        cyc(4);
        chk("slip_off", cnt, 0);
        $display("Test slip done");
        // Fill past full with events masked, then read-strobe selection
        bus(1, `RCLS_OFF_IRQ_MASK, 0);
        bus(0, `RCLS_OFF_IRQ_STAT, 0);
        for (k = 1; k <= 9; k = k + 1)
        begin
            wr <= 1'b1;
            cyc(1);
            wr <= 1'b0;
            cyc(2);
            chk("fifo_err", ferr, k >= 8);
        end
        chk("irq_mask", irq, 0);
        // Bonded as well: the flag must keep working on the shared clock
        bus(1, `RCLS_OFF_CTRL, 32'h90);
        rdd <= 1'b1;
        cyc(1);
        rdd <= 1'b0;
        cyc(2);
        chk("rd_dflt", ferr, 1);
        rdf <= 1'b1;
        cyc(1);
        rdf <= 1'b0;
        cyc(2);
        chk("rd_fab", ferr, 0);
        bus(1, `RCLS_OFF_IRQ_MASK, 32'h4);
        cyc(2);
        chk("irq_fifo", irq, 1);
        $display("Test fifo done");
        report_and_stop;
    end
endmodule // rx_cdr_lock_and_status_tb
